// File: hdl/dvog_pkg.sv
// Shared constants and types for the DAC and output-stage volume register bank.
// Assumes one register clock and an APB master with 32-bit data.
package dvog_pkg;

	// ****************************************************************
	// Register map: index constants, byte address is four times index
	// ****************************************************************
	localparam int unsigned IDX_W = 8;
	localparam int unsigned APB_ADDR_W = 10;
	localparam int unsigned APB_DATA_W = 32;
	localparam int unsigned REG_W = 8;
	localparam int unsigned CODE_W = 7;
	localparam int unsigned ATTEN_W = 10;
	localparam logic [IDX_W-1:0] IDX_LEFT_DAC_VOL = 8'h2B;
	localparam logic [IDX_W-1:0] IDX_RIGHT_DAC_VOL = 8'h2C;
	localparam logic [IDX_W-1:0] IDX_LINE2_HP_GAIN = 8'h2D;
	localparam logic [IDX_W-1:0] IDX_VOL_CTRL = 8'h30;
	localparam logic [IDX_W-1:0] IDX_VOL_STATUS = 8'h31;

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic [REG_W-1:0] RST_DAC_VOL = 8'h80;
	localparam logic [REG_W-1:0] RST_PATH_GAIN = 8'h00;
	localparam logic [REG_W-1:0] RST_VOL_CTRL = 8'h00;
	localparam int unsigned MUTE_BIT = 7;
	localparam int unsigned ROUTE_BIT = 7;
	localparam int unsigned LINK_LSB = 0;
	localparam int unsigned STEP_LSB = 2;
	localparam logic [CODE_W-1:0] DAC_CODE_MAX = 7'h7F;

	// ****************************************************************
	// Output-stage code table breakpoints
	// ****************************************************************
	localparam logic [CODE_W-1:0] SEG_LINEAR_LAST = 7'h24;
	localparam logic [CODE_W-1:0] SEG_OFFSET_LAST = 7'h46;
	localparam logic [CODE_W-1:0] SEG_TAIL_FIRST = 7'h47;
	localparam logic [CODE_W-1:0] OUT_MUTE_FIRST = 7'h76;
	localparam logic [ATTEN_W-1:0] ATTEN_STEP = 10'h005;
	localparam logic [ATTEN_W-1:0] ATTEN_MUTED = 10'h3FF;
	localparam logic [ATTEN_W-1:0] ATTEN_FLOOR = 10'h30F;
	localparam int unsigned MAX_DEST_PER_SOURCE = 7;

	typedef enum logic [1:0] {
		LINK_INDEP = 2'b00,
		LINK_L_FOLLOWS_R = 2'b01,
		LINK_R_FOLLOWS_L = 2'b10,
		LINK_INDEP_ALT = 2'b11
	} dvog_link_t;

	typedef enum logic [1:0] {
		STEP_EVERY_FS = 2'b00,
		STEP_EVERY_2FS = 2'b01,
		STEP_OFF = 2'b10,
		STEP_RSVD = 2'b11
	} dvog_step_t;

	typedef enum logic {
		APB_IDLE = 1'b0,
		APB_ANSWER = 1'b1
	} dvog_apb_state_t;

	typedef struct packed {
		logic mute;
		logic [CODE_W-1:0] atten;
	} dvog_dac_gain_t;

	typedef struct packed {
		logic route;
		logic mute;
		logic [ATTEN_W-1:0] atten;
	} dvog_path_gain_t;

	function automatic logic [APB_ADDR_W-1:0] byte_addr(
		input logic [IDX_W-1:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction

endpackage

// File: hdl/dvog_gain_decode.sv
// Output-stage gain decoder: 7-bit code to attenuation in tenths of a dB.
// Assumes the code and route inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dvog_gain_decode (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic route,
	input wire logic [dvog_pkg::CODE_W-1:0] code,
	output dvog_pkg::dvog_path_gain_t path_reg
);
	import dvog_pkg::*;

	// ****************************************************************
	// Irregular tail of the table, codes 71 to 117
	// ****************************************************************
	localparam logic [ATTEN_W-1:0] TAIL [0:46] = '{
		10'd357, 10'd361, 10'd367, 10'd371, 10'd377, 10'd382, 10'd387,
		10'd392, 10'd397, 10'd402, 10'd407, 10'd412, 10'd417, 10'd422,
		10'd427, 10'd432, 10'd438, 10'd443, 10'd448, 10'd452, 10'd458,
		10'd462, 10'd467, 10'd474, 10'd479, 10'd482, 10'd487, 10'd493,
		10'd500, 10'd503, 10'd510, 10'd514, 10'd518, 10'd522, 10'd527,
		10'd537, 10'd542, 10'd553, 10'd567, 10'd583, 10'd602, 10'd627,
		10'd643, 10'd662, 10'd687, 10'd722, 10'd783};

	// Most of the range is a plain half-dB ladder, so only the tail needs
	// a table; this keeps the decoder small.
	function automatic logic [ATTEN_W-1:0] tenths(
		input logic [CODE_W-1:0] c);
		logic [ATTEN_W-1:0] wide;
		logic [CODE_W-1:0] idx;
		wide = {3'b000, c};
		idx = c - SEG_TAIL_FIRST;
		if (c >= OUT_MUTE_FIRST) begin
			tenths = ATTEN_MUTED;
		end else if (c <= SEG_LINEAR_LAST) begin
			tenths = ATTEN_W'(wide * ATTEN_STEP);
		end else if (c <= SEG_OFFSET_LAST) begin
			tenths = ATTEN_W'(wide * ATTEN_STEP + 10'd1);
		end else begin
			tenths = TAIL[idx[5:0]];
		end
	endfunction

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			path_reg <= '0;
		end else begin
			path_reg.route <= route; // R9
			path_reg.mute <= (code >= OUT_MUTE_FIRST); // R8
			path_reg.atten <= tenths(code); // R7
		end
	end

endmodule
`default_nettype wire

// File: hdl/dvog_soft_step.sv
// Soft-step ramp: moves a gain code toward its target one code per tick or per second tick.
// Assumes tick is a one-cycle sample-rate pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dvog_soft_step (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [dvog_pkg::CODE_W-1:0] target,
	input wire dvog_pkg::dvog_step_t mode,
	input wire logic tick,
	output logic [dvog_pkg::CODE_W-1:0] level_reg,
	output logic busy_reg
);
	import dvog_pkg::*;

	logic half_reg;
	logic stepNow;
	logic [CODE_W-1:0] level_next;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_reg <= 1'b0;
		end else if (tick) begin
			half_reg <= ~half_reg;
		end
	end

	assign stepNow = tick && ((mode == STEP_EVERY_FS) ||
		((mode == STEP_EVERY_2FS) && half_reg)); // R12

	always_comb begin
		level_next = level_reg;
		// The reserved code behaves as stepping off so a bad write cannot
		// freeze the gain.
		if ((mode == STEP_OFF) || (mode == STEP_RSVD)) begin
			level_next = target;
		end else if (stepNow && (level_reg < target)) begin
			level_next = level_reg + 7'h01; // R12
		end else if (stepNow && (level_reg > target)) begin
			level_next = level_reg - 7'h01; // R12
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			level_reg <= RST_PATH_GAIN[CODE_W-1:0];
			busy_reg <= 1'b0;
		end else begin
			level_reg <= level_next;
			busy_reg <= (level_next != target);
		end
	end

endmodule
`default_nettype wire

// File: hdl/dvog_volume_regs.sv
// DAC digital volume and output-stage gain register bank on an APB slave.
// Assumes sampleTick is a one-cycle pulse at the sample rate on ref_clk.
//
// Functional notes
// [R1] Left DAC bit 7 mutes; resets to one.
// [R2] Left DAC code: half-dB cut, resets zero.
// [R3] Right DAC bit 7 mutes; resets to one.
// [R4] Right DAC code: half-dB cut, resets zero.
// [R5] Output path volume spans 0 to -78 dB.
// [R6] Up to seven controls per output-stage signal.
// [R7] Output code table roughly half-dB, coarser end.
// [R8] Output codes 118 to 127 mute completely.
// [R9] Routing bit 7 connects line2 left to headphone.
// [R10] Routing bits 6..0 use shared output table.
// [R11] Link field: left follows right, or reverse.
// [R12] Soft-step gains per fs or per 2fs.
// [R13] Mute overrides code; stored code stays readable.
`timescale 1ns/1ps
`default_nettype none
module dvog_volume_regs #(
	parameter int unsigned ADDR_W = dvog_pkg::APB_ADDR_W,
	parameter int unsigned DEST_COUNT = 1
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [dvog_pkg::APB_DATA_W-1:0] pwdata,
	output logic [dvog_pkg::APB_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sampleTick,
	output dvog_pkg::dvog_dac_gain_t dacLeftOut,
	output dvog_pkg::dvog_dac_gain_t dacRightOut,
	output dvog_pkg::dvog_path_gain_t line2HpOut
);
	import dvog_pkg::*;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	generate
		if (ADDR_W < APB_ADDR_W) begin : gAddrCheck
			$error("ADDR_W too narrow for the register map");
		end
		// A source may feed at most seven independent volume controls.
		if ((DEST_COUNT < 1) || (DEST_COUNT > MAX_DEST_PER_SOURCE)) begin
			: gDestCheck
			$error("DEST_COUNT must lie between 1 and 7"); // R6
		end
	endgenerate

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [REG_W-1:0] leftVol_reg;
	logic [REG_W-1:0] rightVol_reg;
	logic [REG_W-1:0] line2Hp_reg;
	logic [REG_W-1:0] volCtrl_reg;
	dvog_apb_state_t apbState_reg;
	logic [APB_DATA_W-1:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	dvog_dac_gain_t dacLeft_reg;
	dvog_dac_gain_t dacRight_reg;
	logic addrHit;
	logic [REG_W-1:0] readByte;
	logic writeNow;
	logic [REG_W-1:0] wrByte;
	dvog_link_t linkMode;
	dvog_step_t stepMode;
	logic [REG_W-1:0] effLeft;
	logic [REG_W-1:0] effRight;
	logic [CODE_W-1:0] stepLevel;
	logic stepBusy;
	logic [REG_W-1:0] statusByte;

	assign wrByte = pwdata[REG_W-1:0];
	assign linkMode = dvog_link_t'(volCtrl_reg[LINK_LSB +: 2]);
	assign stepMode = dvog_step_t'(volCtrl_reg[STEP_LSB +: 2]);
	assign statusByte = {5'h00, dacRight_reg.mute, dacLeft_reg.mute,
		stepBusy};

	// ****************************************************************
	// Address decode and read mux
	// ****************************************************************
	always_comb begin
		addrHit = 1'b1;
		readByte = 8'h00;
		if (paddr == ADDR_W'(byte_addr(IDX_LEFT_DAC_VOL))) begin
			readByte = leftVol_reg; // R13
		end else if (paddr == ADDR_W'(byte_addr(IDX_RIGHT_DAC_VOL))) begin
			readByte = rightVol_reg;
		end else if (paddr == ADDR_W'(byte_addr(IDX_LINE2_HP_GAIN))) begin
			readByte = line2Hp_reg;
		end else if (paddr == ADDR_W'(byte_addr(IDX_VOL_CTRL))) begin
			readByte = volCtrl_reg;
		end else if (paddr == ADDR_W'(byte_addr(IDX_VOL_STATUS))) begin
			readByte = statusByte;
		end else begin
			addrHit = 1'b0;
		end
	end

	// ****************************************************************
	// APB slave: one wait state, answer registered
	// ****************************************************************
	// The answer is registered so every bus output leaves a flip-flop;
	// the cost is one wait state on every transfer.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			apbState_reg <= APB_IDLE;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			case (apbState_reg)
				APB_IDLE: begin
					if (psel && penable) begin
						apbState_reg <= APB_ANSWER;
						pready_reg <= 1'b1;
						pslverr_reg <= ~addrHit;
						prdata_reg <= pwrite ? '0 :
							{{(APB_DATA_W-REG_W){1'b0}}, readByte};
					end
				end
				APB_ANSWER: begin
					apbState_reg <= APB_IDLE;
					pready_reg <= 1'b0;
					pslverr_reg <= 1'b0;
					prdata_reg <= '0;
				end
				default: begin
					apbState_reg <= APB_IDLE;
					pready_reg <= 1'b0;
				end
			endcase
		end
	end

	assign writeNow = (apbState_reg == APB_ANSWER) && psel && penable &&
		pwrite;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// ****************************************************************
	// Register storage
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			leftVol_reg <= RST_DAC_VOL; // R1 R2
		end else if (writeNow &&
			paddr == ADDR_W'(byte_addr(IDX_LEFT_DAC_VOL))) begin
			leftVol_reg <= wrByte;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rightVol_reg <= RST_DAC_VOL; // R3 R4
		end else if (writeNow &&
			paddr == ADDR_W'(byte_addr(IDX_RIGHT_DAC_VOL))) begin
			rightVol_reg <= wrByte;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			line2Hp_reg <= RST_PATH_GAIN; // R9 R10
		end else if (writeNow &&
			paddr == ADDR_W'(byte_addr(IDX_LINE2_HP_GAIN))) begin
			line2Hp_reg <= wrByte;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			volCtrl_reg <= RST_VOL_CTRL;
		end else if (writeNow &&
			paddr == ADDR_W'(byte_addr(IDX_VOL_CTRL))) begin
			volCtrl_reg <= {4'h0, wrByte[STEP_LSB +: 2], wrByte[LINK_LSB +: 2]};
		end
	end

	// ****************************************************************
	// DAC digital volume with channel link
	// ****************************************************************
	always_comb begin
		effLeft = leftVol_reg;
		effRight = rightVol_reg;
		if (linkMode == LINK_L_FOLLOWS_R) begin
			effLeft = rightVol_reg; // R11
		end else if (linkMode == LINK_R_FOLLOWS_L) begin
			effRight = leftVol_reg; // R11
		end
	end

	// Muting forces full cut on the scaler side only; the register keeps
	// the code so software can restore the level by clearing the mute.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dacLeft_reg <= '{mute: RST_DAC_VOL[MUTE_BIT], atten: DAC_CODE_MAX};
		end else begin
			dacLeft_reg.mute <= effLeft[MUTE_BIT]; // R1
			dacLeft_reg.atten <= effLeft[MUTE_BIT] ? DAC_CODE_MAX :
				effLeft[CODE_W-1:0]; // R2 R13
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dacRight_reg <= '{mute: RST_DAC_VOL[MUTE_BIT], atten: DAC_CODE_MAX};
		end else begin
			dacRight_reg.mute <= effRight[MUTE_BIT]; // R3
			dacRight_reg.atten <= effRight[MUTE_BIT] ? DAC_CODE_MAX :
				effRight[CODE_W-1:0]; // R4 R13
		end
	end

	assign dacLeftOut = dacLeft_reg;
	assign dacRightOut = dacRight_reg;

	// ****************************************************************
	// Output-stage path: line input 2 left into headphone left
	// ****************************************************************
	// The ramp and decoder pair is the unit that is replicated once per
	// destination of a source; this bank carries the first of them.
	dvog_soft_step uStep (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.target(line2Hp_reg[CODE_W-1:0]),
		.mode(stepMode),
		.tick(sampleTick),
		.level_reg(stepLevel),
		.busy_reg(stepBusy)
	); // R12

	dvog_gain_decode uDecode (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.route(line2Hp_reg[ROUTE_BIT]),
		.code(stepLevel),
		.path_reg(line2HpOut)
	); // R5 R6 R10

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	chk_left_mute_out: assert property ( // R1
		(linkMode != LINK_L_FOLLOWS_R) |=>
			dacLeftOut.mute == $past(leftVol_reg[MUTE_BIT]))
		else $error("left DAC mute does not follow its register");

	chk_left_code_out: assert property ( // R2
		(linkMode != LINK_L_FOLLOWS_R) && !leftVol_reg[MUTE_BIT] |=>
			dacLeftOut.atten == $past(leftVol_reg[CODE_W-1:0]))
		else $error("left DAC attenuation does not follow its code");

	chk_right_mute_out: assert property ( // R3
		(linkMode != LINK_R_FOLLOWS_L) |=>
			dacRightOut.mute == $past(rightVol_reg[MUTE_BIT]))
		else $error("right DAC mute does not follow its register");

	chk_right_code_out: assert property ( // R4
		(linkMode != LINK_R_FOLLOWS_L) && !rightVol_reg[MUTE_BIT] |=>
			dacRightOut.atten == $past(rightVol_reg[CODE_W-1:0]))
		else $error("right DAC attenuation does not follow its code");

	chk_link_follow: assert property ( // R11
		(linkMode == LINK_L_FOLLOWS_R) ##1 (linkMode == LINK_L_FOLLOWS_R) |->
			dacLeftOut == dacRightOut)
		else $error("linked left channel differs from right");

	chk_mute_wins: assert property ( // R13
		leftVol_reg[MUTE_BIT] && (linkMode != LINK_L_FOLLOWS_R) |=>
			dacLeftOut.atten == DAC_CODE_MAX &&
			($stable(leftVol_reg[CODE_W-1:0]) || $past(writeNow)))
		else $error("muted left channel lost full cut or stored code");

	chk_path_mute: assert property ( // R8
		(stepLevel >= OUT_MUTE_FIRST) |=> line2HpOut.mute)
		else $error("output code in mute range did not mute");

	chk_path_range: assert property ( // R5
		!line2HpOut.mute |-> line2HpOut.atten <= ATTEN_FLOOR)
		else $error("output attenuation beyond path floor");

	chk_path_ladder: assert property ( // R10
		(stepLevel <= SEG_LINEAR_LAST) |=>
			line2HpOut.atten == ATTEN_W'({3'b000, $past(stepLevel)} * ATTEN_STEP))
		else $error("output ladder code decoded wrongly");

	chk_route_follow: assert property ( // R9
		1'b1 |=> line2HpOut.route == $past(line2Hp_reg[ROUTE_BIT]))
		else $error("routing bit not passed to the path");

	chk_step_hold: assert property ( // R12
		(stepMode == STEP_EVERY_FS || stepMode == STEP_EVERY_2FS) &&
			!sampleTick |=> $stable(stepLevel))
		else $error("soft-step level moved without a sample tick");

	chk_apb_answer: assert property (
		psel && penable && !pready ##1 psel && penable |-> pready)
		else $error("APB slave did not answer after one wait state");

	chk_bad_addr: assert property (
		psel && penable && !pready && !addrHit |=> pready && pslverr)
		else $error("unmapped address was not refused");

	chk_link_right: assert property ( // R11
		(linkMode == LINK_R_FOLLOWS_L) ##1 (linkMode == LINK_R_FOLLOWS_L) |->
			dacRightOut == dacLeftOut)
		else $error("linked right channel differs from left");

	chk_step_up: assert property ( // R12
		(stepMode == STEP_EVERY_FS) && sampleTick &&
			(stepLevel < line2Hp_reg[CODE_W-1:0]) |=>
			stepLevel == $past(stepLevel) + 7'h01)
		else $error("soft-step did not climb one code on a tick");

	chk_step_off: assert property ( // R12
		(stepMode == STEP_OFF) |=>
			stepLevel == $past(line2Hp_reg[CODE_W-1:0]))
		else $error("gain did not jump at once with soft-stepping off");

	chk_status_busy: assert property ( // R12
		1'b1 |=> stepBusy == (stepLevel != $past(line2Hp_reg[CODE_W-1:0])))
		else $error("ramp busy flag disagrees with the applied gain");

	cov_left_write: cover property (
		writeNow && paddr == ADDR_W'(byte_addr(IDX_LEFT_DAC_VOL)));
	cov_link_right: cover property (linkMode == LINK_R_FOLLOWS_L ##1
		dacRightOut == dacLeftOut);
	cov_step_done: cover property (stepBusy ##1 !stepBusy);
	cov_unmapped: cover property (pready && pslverr);
	cov_step_half: cover property (stepMode == STEP_EVERY_2FS && sampleTick &&
		stepBusy);

endmodule
`default_nettype wire

// File: verification/dvog_volume_regs_tb.sv
// Self-checking bench for the DAC and output-stage volume register bank.
// Assumes the one-wait-state APB slave and the registered gain outputs.
`timescale 1ns/1ps
`default_nettype none
module dvog_volume_regs_tb;
	import dvog_pkg::*;

	// ****************************************************************
	// Stimulus, model state and the design under test
	// ****************************************************************
	localparam logic [9:0] A_LEFT = 10'h0AC;
	localparam logic [9:0] A_RIGHT = 10'h0B0;
	localparam logic [9:0] A_HP = 10'h0B4;
	localparam logic [9:0] A_CTRL = 10'h0C0;
	localparam logic [9:0] A_STAT = 10'h0C4;
	logic ref_clk;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic sampleTick = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dvog_dac_gain_t dacLeftOut;
	dvog_dac_gain_t dacRightOut;
	dvog_path_gain_t line2HpOut;
	int fails = 0;
	int total_checks = 0;
	int seed = 32'hf281;
	int cycles = 0;
	int regL = 8'h80;
	int regR = 8'h80;
	int ctrl = 0;
	int effL;
	int effR;
	int n;
	logic [31:0] rd;
	logic [31:0] v;
	logic err;
	// Tail of the output-stage table, codes 71 to 117, in tenths of a dB.
	int tail[47] = '{357, 361, 367, 371, 377, 382, 387, 392, 397, 402, 407,
		412, 417, 422, 427, 432, 438, 443, 448, 452, 458, 462, 467, 474, 479,
		482, 487, 493, 500, 503, 510, 514, 518, 522, 527, 537, 542, 553, 567,
		583, 602, 627, 643, 662, 687, 722, 783};
	logic [9:0] addrs[4] = '{10'h000, 10'h3FC, 10'h0AD, 10'h0B6};

	dvog_volume_regs #(.ADDR_W(10), .DEST_COUNT(7)) i_dvog_volume_regs (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sampleTick(sampleTick),
		.dacLeftOut(dacLeftOut),
		.dacRightOut(dacRightOut),
		.line2HpOut(line2HpOut)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ****************************************************************
	// Model, bus tasks and reporting
	// ****************************************************************
	function automatic int hpAtten(int c);
		if (c <= 36) return c * 5;
		if (c <= 70) return c * 5 + 1;
		return tail[c - 71];
	endfunction

	function automatic logic [11:0] hpExp(int w);
		int c;
		c = w & 127;
		if (c >= 118) return {w[7], 1'b1, 10'h3FF};
		return {w[7], 1'b0, 10'(hpAtten(c))};
	endfunction

	function automatic logic [7:0] dacExp(int r);
		return r[7] ? 8'hFF : {1'b0, r[6:0]};
	endfunction

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The request stays up until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [9:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(k < 50, 1);
	endtask

	task automatic waitc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fails++;
			final_report();
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		waitc(2);
		check(dacLeftOut, 8'hFF);
		check(dacRightOut, 8'hFF);
		check(line2HpOut, 12'h000);
		apb(1'b0, A_LEFT, 0);
		check(rd, 32'h80);
		apb(1'b0, A_RIGHT, 0);
		check(rd, 32'h80);
		apb(1'b0, A_HP, 0);
		check(rd, 32'h0);
		$display("Test reset values done");

		// Unmapped and misaligned places refuse and leave registers alone.
		foreach (addrs[i]) begin
			apb(1'b1, addrs[i], 32'h55);
			check(err, 1'b1);
			apb(1'b0, addrs[i], 0);
			check(err, 1'b1);
			check(rd, 32'h0);
		end
		apb(1'b0, A_LEFT, 0);
		check(rd, 32'h80);
		apb(1'b1, A_STAT, 32'hFF);
		check(err, 1'b0);
		$display("Test address decode done");

		for (int m = 0; m < 4; m++) begin
			ctrl = 8 + m;
			apb(1'b1, A_CTRL, ctrl);
			for (int i = 0; i < 6; i++) begin
				v = $random(seed);
				if (i == 0) v = 32'hFFFF_FF00;
				if (i == 1) v = 32'h0000_007F;
				apb(1'b1, A_LEFT, v);
				regL = v & 255;
				v = $random(seed);
				apb(1'b1, A_RIGHT, v);
				regR = v & 255;
				effL = (m == 1) ? regR : regL;
				effR = (m == 2) ? regL : regR;
				waitc(2);
				check(dacLeftOut, dacExp(effL));
				check(dacRightOut, dacExp(effR));
				apb(1'b0, A_LEFT, 0);
				check(rd, regL);
				apb(1'b0, A_RIGHT, 0);
				check(rd, regR);
				apb(1'b0, A_STAT, 0);
				check(rd, {effR[7], effL[7], 1'b0});
			end
		end
		$display("Test DAC volume and link done");

		// The reserved stepping code must behave as stepping off.
		apb(1'b1, A_CTRL, 12);
		for (int c = 0; c < 128; c++) begin
			v = c | ($random(seed) & 32'h80);
			apb(1'b1, A_HP, v);
			waitc(3);
			check(line2HpOut, hpExp(v));
		end
		apb(1'b0, A_HP, 0);
		check(rd, v & 255);
		$display("Test output-stage table done");

		// One code per tick, or per second tick; the toggle may be odd.
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, A_CTRL, 8);
			apb(1'b1, A_HP, 32'h80);
			waitc(3);
			apb(1'b1, A_CTRL, m * 4);
			apb(1'b1, A_HP, 32'h8C);
			apb(1'b0, A_STAT, 0);
			check(rd & 1, 1);
			check(line2HpOut, 12'h800);
			n = 0;
			while (line2HpOut.atten !== 10'(hpAtten(12)) && n < 40) begin
				@(posedge ref_clk);
				sampleTick <= 1'b1;
				@(posedge ref_clk);
				sampleTick <= 1'b0;
				waitc(3);
				n++;
			end
			check(n >= 12 * (m + 1) - m && n <= 12 * (m + 1), 1);
			apb(1'b0, A_STAT, 0);
			check(rd & 1, 0);
		end
		$display("Test soft-step done");

		// A reset in mid-run must bring back the reset levels: muted DACs and an unmuted 0 dB path.
		@(posedge ref_clk);
		reset_n <= 1'b0;
		waitc(4);
		reset_n <= 1'b1;
		waitc(2);
		check(dacLeftOut, 8'hFF);
		check(dacRightOut, 8'hFF);
		check(line2HpOut, 12'h000);
		apb(1'b0, A_LEFT, 0);
		check(rd, 32'h80);
		apb(1'b0, A_HP, 0);
		check(rd, 32'h0);
		$display("Test mid-run reset done");
		final_report();
	end
endmodule
`default_nettype wire
